/* File: rtl/prlf_framer.sv */
// Primary rate framer: timeslot 0 generation, CRC-4, line coding, receive
// decoding, all-ones alarm detection, test facilities and an AXI4-Lite slave.
// Assumes the receive pins are aligned to the transmit bit timing (loop timed).
`timescale 1ns/1ns

module prlf_framer (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic PAYLOAD_IN,
    output logic PAYLOAD_STROBE,
    input wire logic RX_POS,
    input wire logic RX_NEG,
    output logic TX_POS,
    output logic TX_NEG,
    output logic AIS_ACTIVE,
    output logic REF_LOCK_EN,
    output logic IRQ
);
    logic [15:0] acc;
    logic [16:0] acc_sum;
    logic tick;
    logic [7:0] bit_pos;
    logic [3:0] frame_num;
    logic [31:0] ctrl_word;
    prlf_pkg::prlf_ctrl_type ctrl;
    logic [prlf_pkg::ST_WIDTH-1:0] status;
    logic [prlf_pkg::ST_WIDTH-1:0] mask;
    logic [prlf_pkg::ST_WIDTH-1:0] next_status;
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data, w_bits;
    logic [3:0] crc, crc_hold, next_crc;
    logic [10:0] prbs;
    logic rx_pos_m, rx_pos_s, rx_neg_m, rx_neg_s;
    logic rx_last_pol;
    logic [3:0] rx_dly;
    logic rx_bit, rx_pulse, rx_viol;
    logic [8:0] win_cnt;
    logic [1:0] win_zeros;
    logic win_end, win_ok;
    prlf_pkg::prlf_ais_type ais_state;
    prlf_pkg::prlf_sym_type sym [0:3];
    prlf_pkg::prlf_sym_type next_sym [0:3];
    logic tx_pol, tx_par, next_par;
    logic tx_bit, crc_bit, ts0, even, payload, test_ts, e_bit;
    logic [2:0] idx;
    logic [1:0] c_idx;
    logic [2:0] zero_run;

    assign ctrl = prlf_ctrl_type_from(ctrl_word);
    assign ts0 = (bit_pos[7:3] == 5'h00);
    assign idx = bit_pos[2:0];
    assign even = ~frame_num[0];
    assign c_idx = frame_num[2:1];
    assign test_ts = (bit_pos[7:3] == ctrl.test_ts) && !ts0;
    assign acc_sum = {1'b0, acc} + prlf_pkg::LINE_RATE_KBPS;

    function automatic prlf_pkg::prlf_ctrl_type prlf_ctrl_type_from(input logic [31:0] w);
        prlf_pkg::prlf_ctrl_type c;
        c.sa = w[prlf_pkg::CTRL_SA_LSB +: 5];
        c.test_ts = w[prlf_pkg::CTRL_TS_LSB +: 5];
        c.prbs = w[prlf_pkg::CTRL_PRBS];
        c.ts_loop = w[prlf_pkg::CTRL_TS_LOOP];
        c.loop4 = w[prlf_pkg::CTRL_LOOP4];
        c.defect = w[prlf_pkg::CTRL_DEFECT];
        c.network = w[prlf_pkg::CTRL_NETWORK];
        c.crc_dis = w[prlf_pkg::CTRL_CRC_DIS];
        return c;
    endfunction : prlf_ctrl_type_from

    // Fractional divider: one line bit per tick, 2048 ticks per 50000 clocks on average.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            acc <= 16'h0000;
            tick <= 1'b0;
        end else if (acc_sum >= prlf_pkg::MCLK_KHZ) begin
            acc <= 16'(acc_sum - prlf_pkg::MCLK_KHZ);
            tick <= 1'b1;
        end else begin
            acc <= acc_sum[15:0];
            tick <= 1'b0;
        end
    end

    // Bit and frame position; frames 0 to 7 and 8 to 15 are the two sub-multiframes.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bit_pos <= 8'h00;
            frame_num <= 4'h0;
        end else if (tick) begin
            bit_pos <= bit_pos + 8'h01;
            if (bit_pos == 8'hFF) begin
                frame_num <= frame_num + 4'h1;
            end
        end
    end

    // Remote alarm follows the defect control alone; E bits follow the defect control and the side.
    always_comb begin
        e_bit = !(ctrl.network && ctrl.defect);
    end

    // Payload source for timeslots 1 to 31, test facilities take precedence.
    always_comb begin
        payload = PAYLOAD_IN;
        if (ctrl.loop4) begin
            payload = rx_bit;
        end else if (test_ts && ctrl.prbs) begin
            payload = prbs[10];
        end else if (test_ts && ctrl.ts_loop) begin
            payload = rx_bit;
        end
    end

    // Bit to send at the current position.
    always_comb begin
        tx_bit = payload;
        if (ts0 && even) begin
            if (idx == 3'h0) begin
                tx_bit = ctrl.crc_dis ? 1'b1 : crc_hold[2'h3 - c_idx];
            end else begin
                tx_bit = prlf_pkg::FAS_OCTET[3'h7 - idx];
            end
        end else if (ts0) begin
            if (idx == 3'h0) begin
                if (ctrl.crc_dis) begin
                    tx_bit = 1'b1;
                end else if (frame_num[3:1] < 3'h6) begin
                    tx_bit = prlf_pkg::MFAS_BITS[3'h5 - frame_num[3:1]];
                end else begin
                    tx_bit = e_bit;
                end
            end else if (idx == 3'h1) begin
                tx_bit = 1'b1;
            end else if (idx == 3'h2) begin
                tx_bit = ctrl.defect;
            end else begin
                tx_bit = ctrl.sa[3'h7 - idx];
            end
        end
        crc_bit = (ts0 && even && idx == 3'h0) ? 1'b0 : tx_bit;
        next_crc = {crc[2:0], 1'b0} ^ ((crc_bit ^ crc[3]) ? prlf_pkg::CRC_POLY : 4'h0);
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            crc <= 4'h0;
            crc_hold <= 4'h0;
        end else if (tick && bit_pos == 8'hFF && frame_num[2:0] == 3'h7) begin
            crc_hold <= next_crc;
            crc <= 4'h0;
        end else if (tick) begin
            crc <= next_crc;
        end
    end

    // PRBS advances only inside the chosen timeslot
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            prbs <= prlf_pkg::PRBS_SEED;
        end else if (tick && test_ts) begin
            prbs <= {prbs[9:0], prbs[10] ^ prbs[8]};
        end
    end

    // payload taken in timeslots 1 to 31
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            PAYLOAD_STROBE <= 1'b0;
        end else begin
            PAYLOAD_STROBE <= tick && !ts0;
        end
    end

    // Line coder: four symbols are held back so a zero run can be rewritten.
    always_comb begin
        next_par = tx_par;
        if (sym[3] == prlf_pkg::SYM_ONE || sym[3] == prlf_pkg::SYM_B) begin
            next_par = ~tx_par;
        end else if (sym[3] == prlf_pkg::SYM_V) begin
            next_par = 1'b0;
        end
        next_sym[3] = sym[2];
        next_sym[2] = sym[1];
        next_sym[1] = sym[0];
        next_sym[0] = tx_bit ? prlf_pkg::SYM_ONE : prlf_pkg::SYM_ZERO;
        if (next_sym[0] == prlf_pkg::SYM_ZERO && next_sym[1] == prlf_pkg::SYM_ZERO &&
            next_sym[2] == prlf_pkg::SYM_ZERO && next_sym[3] == prlf_pkg::SYM_ZERO) begin
            next_sym[0] = prlf_pkg::SYM_V;
            next_sym[3] = next_par ? prlf_pkg::SYM_ZERO : prlf_pkg::SYM_B;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            for (int i = 0; i < 4; i++) begin
                sym[i] <= prlf_pkg::SYM_ONE;
            end
            tx_pol <= 1'b0;
            tx_par <= 1'b0;
            TX_POS <= 1'b0;
            TX_NEG <= 1'b0;
        end else if (tick) begin
            for (int i = 0; i < 4; i++) begin
                sym[i] <= next_sym[i];
            end
            tx_par <= next_par;
            TX_POS <= 1'b0;
            TX_NEG <= 1'b0;
            if (sym[3] == prlf_pkg::SYM_ONE || sym[3] == prlf_pkg::SYM_B) begin
                tx_pol <= ~tx_pol;
                TX_POS <= ~tx_pol;
                TX_NEG <= tx_pol;
            end else if (sym[3] == prlf_pkg::SYM_V) begin
                TX_POS <= tx_pol;
                TX_NEG <= ~tx_pol;
            end
        end
    end

    // Two-stage synchronisers for the receive pins.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rx_pos_m <= 1'b0;
            rx_pos_s <= 1'b0;
            rx_neg_m <= 1'b0;
            rx_neg_s <= 1'b0;
        end else begin
            rx_pos_m <= RX_POS;
            rx_pos_s <= rx_pos_m;
            rx_neg_m <= RX_NEG;
            rx_neg_s <= rx_neg_m;
        end
    end

    assign rx_pulse = rx_pos_s | rx_neg_s;
    assign rx_viol = rx_pulse && (rx_pos_s == rx_last_pol);
    assign rx_bit = rx_dly[3];

    // decoder removes substitutions: a violation clears itself and the B three bits back.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rx_last_pol <= 1'b0;
            rx_dly <= 4'h0;
        end else if (tick) begin
            if (rx_pulse) begin
                rx_last_pol <= rx_pos_s;
            end
            rx_dly <= rx_viol ? 4'h0 : {rx_dly[2:0], rx_pulse};
        end
    end

    // zero count over 512-bit windows, pulses of either polarity count as ones
    assign win_end = tick && (win_cnt == prlf_pkg::AIS_LAST_BIT);
    assign win_ok = (win_zeros + {1'b0, !rx_pulse && win_zeros != 2'h3}) <= prlf_pkg::AIS_MAX_ZEROS;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            win_cnt <= 9'h000;
            win_zeros <= 2'h0;
        end else if (win_end) begin
            win_cnt <= 9'h000;
            win_zeros <= 2'h0;
        end else if (tick) begin
            win_cnt <= win_cnt + 9'h001;
            if (!rx_pulse && win_zeros != 2'h3) begin
                win_zeros <= win_zeros + 2'h1;
            end
        end
    end

    // Alarm state is decided once per window, so a few ppm of rate offset only shifts windows.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ais_state <= prlf_pkg::AIS_CLEAR;
        end else if (win_end) begin
            case (ais_state)
                prlf_pkg::AIS_CLEAR: ais_state <= win_ok ? prlf_pkg::AIS_SEEN : prlf_pkg::AIS_CLEAR;
                prlf_pkg::AIS_SEEN: ais_state <= win_ok ? prlf_pkg::AIS_SEEN : prlf_pkg::AIS_CLEAR;
                default: ais_state <= prlf_pkg::AIS_CLEAR;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            AIS_ACTIVE <= 1'b0;
            REF_LOCK_EN <= 1'b0;
        end else begin
            AIS_ACTIVE <= (ais_state == prlf_pkg::AIS_SEEN);
            REF_LOCK_EN <= (ais_state == prlf_pkg::AIS_CLEAR);
        end
    end

    // Sticky events; a new event in the clearing cycle survives the clear.
    always_comb begin
        next_status = status;
        if (aw_got && w_got && !S_AXI_BVALID && aw_addr == prlf_pkg::ADDR_STATUS) begin
            next_status = status & ~w_bits[prlf_pkg::ST_WIDTH-1:0];
        end
        next_status[prlf_pkg::ST_AIS_ON] |= AIS_ACTIVE == 1'b0 && ais_state == prlf_pkg::AIS_SEEN;
        next_status[prlf_pkg::ST_AIS_OFF] |= AIS_ACTIVE == 1'b1 && ais_state == prlf_pkg::AIS_CLEAR;
        next_status[prlf_pkg::ST_MFRAME] |= tick && bit_pos == 8'hFF && frame_num == 4'hF;
    end

    // Write data with unstrobed bytes zeroed at capture; its ones clear the matching status bits.
    assign w_bits = w_data;

    // AXI4-Lite write path: address and data taken in either order, one write at a time.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= prlf_pkg::RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            ctrl_word <= prlf_pkg::CTRL_RESET;
            mask <= '0;
        end else begin
            S_AXI_AWREADY <= S_AXI_AWVALID && !S_AXI_AWREADY && !aw_got && !S_AXI_BVALID;
            S_AXI_WREADY <= S_AXI_WVALID && !S_AXI_WREADY && !w_got && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got <= 1'b1;
                for (int b = 0; b < 4; b++) begin
                    w_data[b*8 +: 8] <= S_AXI_WSTRB[b] ? S_AXI_WDATA[b*8 +: 8] : 8'h00;
                end
            end
            if (aw_got && w_got && !S_AXI_BVALID) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= prlf_pkg::RESP_OKAY;
                if (aw_addr == prlf_pkg::ADDR_CTRL) begin
                    ctrl_word <= w_data & prlf_pkg::CTRL_MASK;
                end else if (aw_addr == prlf_pkg::ADDR_MASK) begin
                    mask <= w_data[prlf_pkg::ST_WIDTH-1:0];
                end else if (aw_addr != prlf_pkg::ADDR_STATUS && aw_addr != prlf_pkg::ADDR_STATE) begin
                    S_AXI_BRESP <= prlf_pkg::RESP_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path; unmapped addresses answer with SLVERR and zero data.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= prlf_pkg::RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= prlf_pkg::RESP_OKAY;
                if (S_AXI_ARADDR == prlf_pkg::ADDR_CTRL) begin
                    S_AXI_RDATA <= ctrl_word;
                end else if (S_AXI_ARADDR == prlf_pkg::ADDR_STATUS) begin
                    S_AXI_RDATA <= {29'h0, status};
                end else if (S_AXI_ARADDR == prlf_pkg::ADDR_MASK) begin
                    S_AXI_RDATA <= {29'h0, mask};
                end else if (S_AXI_ARADDR == prlf_pkg::ADDR_STATE) begin
                    S_AXI_RDATA <= {16'h0, bit_pos, frame_num, 3'h0, AIS_ACTIVE};
                end else begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= prlf_pkg::RESP_SLVERR;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Status register and level interrupt from unmasked events.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            status <= '0;
            IRQ <= 1'b0;
        end else begin
            status <= next_status;
            IRQ <= |(next_status & mask);
        end
    end

    // Helper for the checks: line ticks since the last pulse.
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            zero_run <= 3'h0;
        end else if (tick) begin
            zero_run <= (sym[3] == prlf_pkg::SYM_ZERO) ? zero_run + 3'h1 : 3'h0;
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);

    sequence ais_window_ok;
        win_end && win_ok;
    endsequence

    sequence ais_window_bad;
        win_end && !win_ok;
    endsequence

    zero_run_a: assert property (zero_run <= 3'h3)
        else $error("more than three zeros on the line");
    polar_excl_a: assert property (!(TX_POS && TX_NEG))
        else $error("both line polarities driven");
    fas_word_a: assert property (ts0 && even && idx != 3'h0 |-> tx_bit == prlf_pkg::FAS_OCTET[3'h7 - idx])
        else $error("frame alignment bit wrong");
    crc_off_a: assert property (ctrl.crc_dis && ts0 && idx == 3'h0 |-> tx_bit)
        else $error("bit one low with CRC disabled");
    e_bit_a: assert property (ts0 && !even && idx == 3'h0 && frame_num[3:1] >= 3'h6 && !ctrl.crc_dis
        |-> tx_bit == !(ctrl.network && ctrl.defect))
        else $error("E bit does not follow defect");
    c_insert_a: assert property (tick && bit_pos == 8'hFF && frame_num[2:0] == 3'h7 ##1 ts0 && even && idx == 3'h0
        && !ctrl.crc_dis |-> tx_bit == crc_hold[3])
        else $error("C1 is not the held remainder");
    // The state moves one cycle after the window end and the output flop follows a cycle later.
    ais_accept_a: assert property (ais_window_ok |=> ##1 AIS_ACTIVE)
        else $error("alarm not accepted on good window");
    ais_hold_a: assert property ($fell(AIS_ACTIVE) |-> $past(win_end && !win_ok, 2))
        else $error("alarm dropped without a bad window");
    ref_lock_a: assert property (ais_window_ok |-> ##2 !REF_LOCK_EN)
        else $error("reference lock kept during alarm");
    loop4_a: assert property (ctrl.loop4 && !ts0 |-> tx_bit == rx_bit)
        else $error("loopback payload mismatch");
endmodule : prlf_framer

/* File: rtl/prlf_pkg.sv */
// Package of the primary rate layer-1 framer: register map, field positions,
// frame constants and the shared types. Assumes a 50 MHz system clock.
package prlf_pkg;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    // Control field positions.
    localparam int CTRL_CRC_DIS = 0;
    localparam int CTRL_NETWORK = 1;
    localparam int CTRL_DEFECT = 2;
    localparam int CTRL_LOOP4 = 3;
    localparam int CTRL_TS_LOOP = 4;
    localparam int CTRL_PRBS = 5;
    localparam int CTRL_TS_LSB = 8;
    localparam int CTRL_SA_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h001F0000;
    localparam logic [31:0] CTRL_MASK = 32'h001F1F3F;
    // Status event bits, cleared by writing a one.
    localparam int ST_AIS_ON = 0;
    localparam int ST_AIS_OFF = 1;
    localparam int ST_MFRAME = 2;
    localparam int ST_WIDTH = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Line rate against the system clock, used by the bit tick accumulator.
    localparam logic [16:0] LINE_RATE_KBPS = 17'h00800;
    localparam logic [16:0] MCLK_KHZ = 17'h0C350;
    // Timeslot 0 patterns, bit 1 of the octet is the leftmost.
    localparam logic [7:0] FAS_OCTET = 8'h1B;
    localparam logic [5:0] MFAS_BITS = 6'h0B;
    localparam logic [3:0] CRC_POLY = 4'h3;
    localparam logic [10:0] PRBS_SEED = 11'h7FF;
    // All-ones alarm detection window.
    localparam logic [8:0] AIS_LAST_BIT = 9'h1FF;
    localparam logic [1:0] AIS_MAX_ZEROS = 2'h2;

    typedef enum logic [1:0] {
        SYM_ZERO = 2'b00,
        SYM_ONE = 2'b01,
        SYM_B = 2'b10,
        SYM_V = 2'b11
    } prlf_sym_type;

    typedef enum logic {
        AIS_CLEAR = 1'b0,
        AIS_SEEN = 1'b1
    } prlf_ais_type;

    typedef struct packed {
        logic [4:0] sa;
        logic [4:0] test_ts;
        logic prbs;
        logic ts_loop;
        logic loop4;
        logic defect;
        logic network;
        logic crc_dis;
    } prlf_ctrl_type;
endpackage : prlf_pkg

/* File: tb/prlf_far_end.sv */
// Far-end line model: silent, or all ones with two or three zeros per 512 bits.
// Assumes it shares the framer's clock and reset; bit ticks come from a rate accumulator.
`timescale 1ns/1ns
module prlf_far_end (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [1:0] ZEROS,
    output logic RX_POS,
    output logic RX_NEG,
    output logic TICK
);
    logic [16:0] acc;
    logic [8:0] pos;
    logic pol;
    logic mark;
    // Zeros lie far apart, so every 512-bit window holds the same count.
    assign mark = (ZEROS != 2'h0) && pos != 9'h064 && pos != 9'h12C && !(ZEROS == 2'h3 && pos == 9'h190);
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            acc <= 17'h00000;
            pos <= 9'h000;
            pol <= 1'b0;
            TICK <= 1'b0;
            RX_POS <= 1'b0;
            RX_NEG <= 1'b0;
        end else if (acc + 17'h00800 >= 17'h0C350) begin
            acc <= acc + 17'h00800 - 17'h0C350;
            pos <= pos + 9'h001;
            TICK <= 1'b1;
            RX_POS <= mark && !pol;
            RX_NEG <= mark && pol;
            pol <= pol ^ mark;
        end else begin
            acc <= acc + 17'h00800;
            TICK <= 1'b0;
        end
    end
endmodule : prlf_far_end

/* File: tb/testbench.sv */
// Testbench: registers, framing and line code, alarm detection and interrupts.
// Assumes the far-end model ticks in step with the framer's own bit rate.
`timescale 1ns/1ns
module testbench;
    logic MCLK = 1'b0;
    logic SRST = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pay = 1;
    logic [1:0] zeros = 2'h0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid, rxp, rxn, tick, txp, txn, ais, lock, irq;
    logic [511:0] hist = '0;
    logic lastpol = 0, lastv = 0, vseen = 0, mon = 0, exp_a = 0, exp_c = 0, dense = 0;
    int mismatches = 0, checks = 0, n = 0, lasthit = 0, hits = 0, run = 0, t;

    always #10 MCLK = ~MCLK;

    prlf_framer uut (.MCLK(MCLK), .SRST(SRST), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PAYLOAD_IN(pay),
        .PAYLOAD_STROBE(), .RX_POS(rxp), .RX_NEG(rxn), .TX_POS(txp), .TX_NEG(txn),
        .AIS_ACTIVE(ais), .REF_LOCK_EN(lock), .IRQ(irq));
    prlf_far_end far (.MCLK(MCLK), .SRST(SRST), .ZEROS(zeros), .RX_POS(rxp), .RX_NEG(rxn), .TICK(tick));

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task close_out;
        $display("%0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // Bus writes hold each channel until its own ready; the answer is awaited.
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge MCLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", bresp, resp);
    endtask : axw

    task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge MCLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", rdata, d);
        chk("rresp", rresp, resp);
    endtask : axr

    // Line decoder: undoes zero substitution and checks each aligned frame pair.
    always @(posedge MCLK) if (tick) begin
        hist = {hist[510:0], txp | txn};
        if (txp | txn) begin
            if (txp == lastpol) begin
                if (mon && vseen) chk("v_polarity", txp, !lastv);
                vseen = 1;
                lastv = txp;
                hist[3:0] = 4'h0;
            end
            lastpol = txp;
            run = 0;
        end else run++;
        if (mon) chk("mark_run", {txp & txn, run > 3}, 0);
        n++;
        if (hist[6:0] == 7'b0011011) begin
            if (mon) begin
                chk("fas_gap", n - lasthit, 512);
                chk("odd_bits", hist[262:256], {1'b1, exp_a, 5'h1F});
                if (exp_c) chk("crc_off", hist[7], 1);
                chk("dense", $countones(hist) > 480, dense);
            end
            hits++;
            lasthit = n;
        end
    end

    task frames(input logic [31:0] ctrl, input logic p, a, c, d);
        axw(prlf_pkg::ADDR_CTRL, ctrl, prlf_pkg::RESP_OKAY);
        pay <= p;
        exp_a = a;
        exp_c = c;
        dense = d;
        t = hits;
        while (hits < t + 1) @(posedge MCLK);
        mon = 1;
        while (hits < t + 2) @(posedge MCLK);
        mon = 0;
    endtask : frames

    task t_regs;
        axr(prlf_pkg::ADDR_CTRL, prlf_pkg::CTRL_RESET, prlf_pkg::RESP_OKAY);
        axr(prlf_pkg::ADDR_MASK, 0, prlf_pkg::RESP_OKAY);
        axr(8'h10, 0, prlf_pkg::RESP_SLVERR);
        axw(8'h10, 32'hFFFFFFFF, prlf_pkg::RESP_SLVERR);
        axr(prlf_pkg::ADDR_CTRL, prlf_pkg::CTRL_RESET, prlf_pkg::RESP_OKAY);
        $display("test regs done");
    endtask : t_regs

    // The far end has been sending the alarm pattern since the defect frames began.
    task t_alarm;
        for (t = 0; t < 40000 && !ais; t++) @(posedge MCLK);
        chk("ais_lock", {ais, lock}, 2'b10);
        axw(prlf_pkg::ADDR_MASK, 32'h3, prlf_pkg::RESP_OKAY);
        for (t = 0; t < 8 && !irq; t++) @(posedge MCLK);
        chk("irq_on", irq, 1);
        axw(prlf_pkg::ADDR_STATUS, 32'h7, prlf_pkg::RESP_OKAY);
        repeat (2) @(posedge MCLK);
        chk("irq_clear", irq, 0);
        // Looped payload is the received alarm pattern, so it is dense although the local payload is zero.
        frames(32'h001F0008, 1'b0, 1'b0, 1'b0, 1'b1);
        chk("ais_hold", {ais, irq}, 2'b10);
        zeros <= 2'h3;
        for (t = 0; t < 40000 && ais; t++) @(posedge MCLK);
        chk("ais_lock", {ais, lock}, 2'b01);
        $display("test alarm done");
    endtask : t_alarm

    initial begin
        #2000000;
        mismatches++;
        $display("watchdog expired");
        close_out;
    end

    initial begin
        repeat (5) @(posedge MCLK);
        SRST <= 1'b0;
        t_regs;
        frames(32'h001F0000, 1'b1, 1'b0, 1'b0, 1'b1);
        $display("test normal frames done");
        zeros <= 2'h2;
        frames(32'h001F0007, 1'b0, 1'b1, 1'b1, 1'b0);
        $display("test defect frames done");
        t_alarm;
        close_out;
    end
endmodule : testbench
